// file: logic/hts_pkg.sv
// constants, encodings and state types shared by the sensor serial target
package hts_pkg;
    localparam logic [6:0] TARGET_ADDR = 7'h44;
    localparam int CLK_MHZ = 25;
    localparam int TIMER_W = 20;
    // times in microseconds, cycle counts derived from the core clock
    localparam int WAKE_US = 100;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int CONV8_US = 550;
    localparam int CONV10_US = 1310;
    localparam int CONV12_US = 4500;
    localparam int CONV14_US = 16900;
    localparam int CONV8_CYC = CONV8_US * CLK_MHZ;
    localparam int CONV10_CYC = CONV10_US * CLK_MHZ;
    localparam int CONV12_CYC = CONV12_US * CLK_MHZ;
    localparam int CONV14_CYC = CONV14_US * CLK_MHZ;
    localparam int POWERUP_WIN_US = 10000;
    localparam int POWERUP_WIN_CYC = POWERUP_WIN_US * CLK_MHZ;
    localparam int NVM_LOAD_US = 120;
    localparam int NVM_LOAD_CYC = NVM_LOAD_US * CLK_MHZ;
    localparam int NVM_COMMIT_US = 14000;
    localparam int NVM_COMMIT_CYC = NVM_COMMIT_US * CLK_MHZ;
    // command bytes and register addresses
    localparam logic [7:0] CMD_PROG_ENTER = 8'ha0;
    localparam logic [7:0] CMD_PROG_EXIT = 8'h80;
    localparam logic [7:0] REG_HUM_RES_RD = 8'h06;
    localparam logic [7:0] REG_TMP_RES_RD = 8'h11;
    localparam logic [7:0] REG_ID_UPPER = 8'h1e;
    localparam logic [7:0] REG_ID_LOWER = 8'h1f;
    localparam logic [7:0] REG_HUM_RES_WR = 8'h46;
    localparam logic [7:0] REG_TMP_RES_WR = 8'h51;
    localparam int RES_LSB = 10;
    localparam logic [15:0] RES_WORD_RESET = 16'h0c00;
    localparam logic [1:0] STATUS_VALID = 2'h0;
    localparam logic [1:0] STATUS_STALE = 2'h1;
    localparam logic [7:0] FILL_BYTE = 8'hff;
    typedef enum logic [2:0] {
        L_IDLE, L_ADDR, L_ADDR_ACK, L_WR_BYTE, L_WR_ACK, L_RD_BYTE, L_RD_ACK
    } hts_link_state_t;
    typedef enum logic [2:0] {
        C_SLEEP, C_WAKE, C_HUM, C_TEMP, C_UPDATE
    } hts_core_state_t;
endpackage

// file: logic/hts_sensor_target.sv
// serial target, measurement sequencer and non-volatile registers of the sensor
// How it works
// - only transfers to target address 0x44 are acknowledged, others are ignored
// - link logic oversamples the serial lines, serving both 100 kHz and 400 kHz
// - data sampled on rising clock edge; changes only while clock is low
// - each byte is 8 bits plus response bit, 0 acknowledge, 1 not-acknowledge
// - after power-up the core sleeps and converts only on a measurement request
// - address with write bit and no data wakes the core for one cycle
// - cycle converts humidity, then temperature, updates output, then sleeps
// - both results delivered as 14 bits, most significant byte first
// - address with read bit is acknowledged and followed by result bytes
// - bytes one and two hold two status bits on top, then 14 humidity bits
// - bytes three and four hold temperature left-aligned, low two bits zero
// - bytes keep coming until the controller answers not-acknowledge and STOP
// - status 00 when not yet fetched since last cycle, 01 once fetched
// - fetch before or during the first measurement returns the stale code
// - measurement time is wake-up 0.1 ms plus both conversion times
// - bytes A0 00 00 within 10 ms of power-up enter programming mode
// - programming entry takes 120 us before registers may be accessed
// - every non-volatile register is 16 bits wide
// - bytes 80 00 00 leave programming mode and resume measurements
// - resolution field bits 11:10, humidity 0x06/0x46, temperature 0x11/0x51
// - identifier upper half at 0x1e, lower half at 0x1f
// - resolutions default to 14 bits; codes 0 to 3 mean 8, 10, 12, 14
// - a register write takes 14 ms to commit; controller waits meanwhile
`timescale 1ns/1ps
`default_nettype none
module hts_sensor_target #(
    parameter int CONV8_CYC = hts_pkg::CONV8_CYC,
    parameter int CONV10_CYC = hts_pkg::CONV10_CYC,
    parameter int CONV12_CYC = hts_pkg::CONV12_CYC,
    parameter int CONV14_CYC = hts_pkg::CONV14_CYC,
    parameter int POWERUP_WIN_CYC = hts_pkg::POWERUP_WIN_CYC,
    parameter int NVM_COMMIT_CYC = hts_pkg::NVM_COMMIT_CYC,
    parameter logic [31:0] SENSOR_ID = 32'h1234_5678 // arbitrary value
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [13:0] humid_raw_i,
    input wire logic [13:0] temp_raw_i,
    output logic core_awake_o,
    output logic prog_mode_o,
    output logic nvm_busy_o
);
    import hts_pkg::*;

    if (CONV14_CYC >= 2 ** TIMER_W || NVM_COMMIT_CYC >= 2 ** TIMER_W
        || POWERUP_WIN_CYC >= 2 ** TIMER_W || CONV8_CYC < 1)
    begin : g_check
        $error("cycle counts do not fit the timers");
    end

    function automatic logic [TIMER_W-1:0] conv_load(input logic [1:0] res);
        int c;
        case (res)
            2'h0: c = CONV8_CYC;
            2'h1: c = CONV10_CYC;
            2'h2: c = CONV12_CYC;
            default: c = CONV14_CYC;
        endcase
        return TIMER_W'(c - 1);
    endfunction

    // lower resolutions leave the dropped bits at zero but keep the 14-bit scale
    function automatic logic [13:0] res_mask(input logic [1:0] res);
        return 14'h3fff << (6 - 2 * res);
    endfunction

    // link-domain reset follows the core reset through two flops
    logic lrst_m_reg, lrst_reg;
    logic scl_m_reg, scl_s_reg, scl_q_reg, sda_m_reg, sda_s_reg, sda_q_reg;
    logic pub_m_reg, pub_s_reg, pub_q_reg, done_m_reg, done_s_reg, done_q_reg;
    hts_link_state_t lst_reg, lst_next;
    logic [3:0] bit_reg, bit_next;
    logic [7:0] sh_reg, sh_next;
    logic [2:0] wcnt_reg, wcnt_next, ridx_reg, ridx_next;
    logic in_wr_reg, in_wr_next, oe_reg, oe_next, stale_reg, stale_next;
    logic meas_tgl_reg, meas_tgl_next, cmd_tgl_reg, cmd_tgl_next;
    logic [7:0] cmd0_reg, cmd0_next, cmd1_reg, cmd1_next, cmd2_reg, cmd2_next;
    logic [13:0] lhum_reg, lhum_next, ltmp_reg, ltmp_next;
    logic lprog_reg, lprog_next, lbusy_reg, lbusy_next;
    logic [15:0] lword_reg, lword_next;

    // core-side values published to the link, held until the next publish
    logic [13:0] hum_out_reg, hum_out_next, tmp_out_reg, tmp_out_next;
    logic prog_reg, prog_next, busy_reg, busy_next;
    logic [15:0] rd_word_reg, rd_word_next;
    logic pub_tgl_reg, pub_tgl_next, done_tgl_reg, done_tgl_next;

    function automatic logic [7:0] read_byte(input logic [2:0] idx);
        logic [7:0] b;
        b = FILL_BYTE;
        if (lprog_reg)
        begin
            case (idx)
                3'h0: b = {6'h0, lbusy_reg, lprog_reg};
                3'h1: b = lword_reg[15:8];
                3'h2: b = lword_reg[7:0];
                default: b = FILL_BYTE;
            endcase
        end
        else
        begin
            case (idx)
                3'h0: b = {(stale_reg ? STATUS_STALE : STATUS_VALID), lhum_reg[13:8]};
                3'h1: b = lhum_reg[7:0];
                3'h2: b = ltmp_reg[13:6];
                3'h3: b = {ltmp_reg[5:0], 2'h0};
                default: b = FILL_BYTE;
            endcase
        end
        return b;
    endfunction

    logic scl_rise, scl_fall, start_ev, stop_ev, pub_ev, done_ev;
    assign scl_rise = scl_s_reg & ~scl_q_reg;
    assign scl_fall = ~scl_s_reg & scl_q_reg;
    assign start_ev = scl_s_reg & scl_q_reg & sda_q_reg & ~sda_s_reg;
    assign stop_ev = scl_s_reg & scl_q_reg & ~sda_q_reg & sda_s_reg;
    assign pub_ev = pub_s_reg ^ pub_q_reg;
    assign done_ev = done_s_reg ^ done_q_reg;

    always_comb
    begin
        lst_next = lst_reg;
        bit_next = bit_reg;
        sh_next = sh_reg;
        wcnt_next = wcnt_reg;
        ridx_next = ridx_reg;
        in_wr_next = in_wr_reg;
        oe_next = oe_reg;
        stale_next = stale_reg;
        meas_tgl_next = meas_tgl_reg;
        cmd_tgl_next = cmd_tgl_reg;
        cmd0_next = cmd0_reg;
        cmd1_next = cmd1_reg;
        cmd2_next = cmd2_reg;
        lhum_next = pub_ev ? hum_out_reg : lhum_reg;
        ltmp_next = pub_ev ? tmp_out_reg : ltmp_reg;
        lprog_next = pub_ev ? prog_reg : lprog_reg;
        lbusy_next = pub_ev ? busy_reg : lbusy_reg;
        lword_next = pub_ev ? rd_word_reg : lword_reg;
        if (done_ev)
            stale_next = 1'b0;
        if (start_ev || stop_ev)
        begin
            // a write ends here: no data bytes asks for a measurement
            if (in_wr_reg && wcnt_reg == 3'h0)
                meas_tgl_next = ~meas_tgl_reg;
            if (in_wr_reg && wcnt_reg == 3'h3)
                cmd_tgl_next = ~cmd_tgl_reg;
            in_wr_next = 1'b0;
            oe_next = 1'b0;
            bit_next = 4'h0;
            lst_next = start_ev ? L_ADDR : L_IDLE;
        end
        else
        begin
            case (lst_reg)
                L_ADDR, L_WR_BYTE:
                begin
                    if (scl_rise)
                    begin
                        sh_next = {sh_reg[6:0], sda_s_reg};
                        bit_next = bit_reg + 4'h1;
                    end
                    else if (scl_fall && bit_reg == 4'h8)
                    begin
                        bit_next = 4'h0;
                        if (lst_reg == L_WR_BYTE)
                        begin
                            case (wcnt_reg)
                                3'h0: cmd0_next = sh_reg;
                                3'h1: cmd1_next = sh_reg;
                                3'h2: cmd2_next = sh_reg;
                                default: cmd2_next = cmd2_reg;
                            endcase
                            if (wcnt_reg != 3'h4)
                                wcnt_next = wcnt_reg + 3'h1;
                            oe_next = 1'b1;
                            lst_next = L_WR_ACK;
                        end
                        else if (sh_reg[7:1] == TARGET_ADDR)
                        begin
                            oe_next = 1'b1;
                            lst_next = L_ADDR_ACK;
                        end
                        else
                            lst_next = L_IDLE;
                    end
                end
                L_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (sh_reg[0])
                        begin
                            // status goes out with the old flag, then the data counts as fetched
                            sh_next = read_byte(3'h0);
                            ridx_next = 3'h1;
                            if (!lprog_reg)
                                stale_next = 1'b1;
                            oe_next = ~sh_next[7];
                            lst_next = L_RD_BYTE;
                        end
                        else
                        begin
                            in_wr_next = 1'b1;
                            wcnt_next = 3'h0;
                            oe_next = 1'b0;
                            lst_next = L_WR_BYTE;
                        end
                    end
                end
                L_WR_ACK:
                begin
                    if (scl_fall)
                    begin
                        oe_next = 1'b0;
                        lst_next = L_WR_BYTE;
                    end
                end
                L_RD_BYTE:
                begin
                    if (scl_fall)
                    begin
                        bit_next = bit_reg + 4'h1;
                        sh_next = {sh_reg[6:0], 1'b1};
                        if (bit_reg == 4'h7)
                        begin
                            oe_next = 1'b0;
                            lst_next = L_RD_ACK;
                        end
                        else
                            oe_next = ~sh_reg[6];
                    end
                end
                L_RD_ACK:
                begin
                    if (scl_rise)
                        bit_next = {3'h0, sda_s_reg};
                    else if (scl_fall)
                    begin
                        if (bit_reg[0])
                            lst_next = L_IDLE;
                        else
                        begin
                            sh_next = read_byte(ridx_reg);
                            oe_next = ~sh_next[7];
                            if (ridx_reg != 3'h7)
                                ridx_next = ridx_reg + 3'h1;
                            bit_next = 4'h0;
                            lst_next = L_RD_BYTE;
                        end
                    end
                end
                default:
                    oe_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge link_clk_i)
    begin
        lrst_m_reg <= rst_i;
        lrst_reg <= lrst_m_reg;
        scl_m_reg <= scl_i;
        scl_s_reg <= scl_m_reg;
        scl_q_reg <= scl_s_reg;
        sda_m_reg <= sda_i;
        sda_s_reg <= sda_m_reg;
        sda_q_reg <= sda_s_reg;
        pub_m_reg <= pub_tgl_reg;
        pub_s_reg <= pub_m_reg;
        pub_q_reg <= pub_s_reg;
        done_m_reg <= done_tgl_reg;
        done_s_reg <= done_m_reg;
        done_q_reg <= done_s_reg;
        if (lrst_reg)
        begin
            lst_reg <= L_IDLE;
            bit_reg <= 4'h0;
            sh_reg <= 8'h00;
            wcnt_reg <= 3'h0;
            ridx_reg <= 3'h0;
            in_wr_reg <= 1'b0;
            oe_reg <= 1'b0;
            stale_reg <= 1'b1;
            meas_tgl_reg <= 1'b0;
            cmd_tgl_reg <= 1'b0;
            cmd0_reg <= 8'h00;
            cmd1_reg <= 8'h00;
            cmd2_reg <= 8'h00;
            lhum_reg <= 14'h0000;
            ltmp_reg <= 14'h0000;
            lprog_reg <= 1'b0;
            lbusy_reg <= 1'b0;
            lword_reg <= 16'h0000;
        end
        else
        begin
            lst_reg <= lst_next;
            bit_reg <= bit_next;
            sh_reg <= sh_next;
            wcnt_reg <= wcnt_next;
            ridx_reg <= ridx_next;
            in_wr_reg <= in_wr_next;
            oe_reg <= oe_next;
            stale_reg <= stale_next;
            meas_tgl_reg <= meas_tgl_next;
            cmd_tgl_reg <= cmd_tgl_next;
            cmd0_reg <= cmd0_next;
            cmd1_reg <= cmd1_next;
            cmd2_reg <= cmd2_next;
            lhum_reg <= lhum_next;
            ltmp_reg <= ltmp_next;
            lprog_reg <= lprog_next;
            lbusy_reg <= lbusy_next;
            lword_reg <= lword_next;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = oe_reg;

    // core domain; command bytes stay put until the next write, far beyond the sync delay
    logic mt_m_reg, mt_s_reg, mt_q_reg, ct_m_reg, ct_s_reg, ct_q_reg;
    hts_core_state_t cst_reg, cst_next;
    logic [TIMER_W-1:0] ctim_reg, ctim_next, ntim_reg, ntim_next, win_reg, win_next;
    logic [13:0] hum_cap_reg, hum_cap_next;
    logic [15:0] hum_word_reg, hum_word_next, tmp_word_reg, tmp_word_next;
    logic meas_ev, cmd_ev, zeros, win_open;
    assign meas_ev = mt_s_reg ^ mt_q_reg;
    assign cmd_ev = ct_s_reg ^ ct_q_reg;
    assign zeros = cmd1_reg == 8'h00 && cmd2_reg == 8'h00;
    assign win_open = win_reg < TIMER_W'(POWERUP_WIN_CYC);

    always_comb
    begin
        cst_next = cst_reg;
        ctim_next = (ctim_reg != '0) ? ctim_reg - 1'b1 : ctim_reg;
        ntim_next = (ntim_reg != '0) ? ntim_reg - 1'b1 : ntim_reg;
        win_next = win_open ? win_reg + 1'b1 : win_reg;
        hum_cap_next = hum_cap_reg;
        hum_out_next = hum_out_reg;
        tmp_out_next = tmp_out_reg;
        hum_word_next = hum_word_reg;
        tmp_word_next = tmp_word_reg;
        prog_next = prog_reg;
        busy_next = busy_reg && ntim_reg != '0;
        rd_word_next = rd_word_reg;
        done_tgl_next = done_tgl_reg;
        case (cst_reg)
            C_SLEEP:
                if (meas_ev && !prog_reg)
                begin
                    ctim_next = TIMER_W'(WAKE_CYC - 1);
                    cst_next = C_WAKE;
                end
            C_WAKE:
                if (ctim_reg == '0)
                begin
                    ctim_next = conv_load(hum_word_reg[RES_LSB+:2]);
                    cst_next = C_HUM;
                end
            C_HUM:
                if (ctim_reg == '0)
                begin
                    hum_cap_next = humid_raw_i & res_mask(hum_word_reg[RES_LSB+:2]);
                    ctim_next = conv_load(tmp_word_reg[RES_LSB+:2]);
                    cst_next = C_TEMP;
                end
            C_TEMP:
                if (ctim_reg == '0)
                begin
                    tmp_out_next = temp_raw_i & res_mask(tmp_word_reg[RES_LSB+:2]);
                    hum_out_next = hum_cap_reg;
                    cst_next = C_UPDATE;
                end
            C_UPDATE:
            begin
                done_tgl_next = ~done_tgl_reg;
                cst_next = C_SLEEP;
            end
            default:
                cst_next = C_SLEEP;
        endcase
        if (cmd_ev && !busy_reg)
        begin
            if (!prog_reg)
            begin
                if (cmd0_reg == CMD_PROG_ENTER && zeros && win_open && cst_reg == C_SLEEP)
                begin
                    prog_next = 1'b1;
                    busy_next = 1'b1;
                    ntim_next = TIMER_W'(NVM_LOAD_CYC - 1);
                end
            end
            else if (cmd0_reg == CMD_PROG_EXIT && zeros)
                prog_next = 1'b0;
            else if (cmd0_reg == REG_HUM_RES_WR || cmd0_reg == REG_TMP_RES_WR)
            begin
                if (cmd0_reg == REG_HUM_RES_WR)
                    hum_word_next = {cmd1_reg, cmd2_reg};
                else
                    tmp_word_next = {cmd1_reg, cmd2_reg};
                busy_next = 1'b1;
                ntim_next = TIMER_W'(NVM_COMMIT_CYC - 1);
            end
            else if (zeros)
            begin
                case (cmd0_reg)
                    REG_HUM_RES_RD: rd_word_next = hum_word_reg;
                    REG_TMP_RES_RD: rd_word_next = tmp_word_reg;
                    REG_ID_UPPER: rd_word_next = SENSOR_ID[31:16];
                    REG_ID_LOWER: rd_word_next = SENSOR_ID[15:0];
                    default: rd_word_next = 16'h0000;
                endcase
                busy_next = 1'b1;
                ntim_next = TIMER_W'(NVM_LOAD_CYC - 1);
            end
        end
        pub_tgl_next = pub_tgl_reg ^ ({hum_out_next, tmp_out_next, prog_next, busy_next,
            rd_word_next} != {hum_out_reg, tmp_out_reg, prog_reg, busy_reg, rd_word_reg});
    end

    always_ff @(posedge clk_i)
    begin
        mt_m_reg <= meas_tgl_reg;
        mt_s_reg <= mt_m_reg;
        ct_m_reg <= cmd_tgl_reg;
        ct_s_reg <= ct_m_reg;
        if (rst_i)
        begin
            mt_q_reg <= 1'b0;
            ct_q_reg <= 1'b0;
            cst_reg <= C_SLEEP;
            ctim_reg <= '0;
            ntim_reg <= '0;
            win_reg <= '0;
            hum_cap_reg <= 14'h0000;
            hum_out_reg <= 14'h0000;
            tmp_out_reg <= 14'h0000;
            hum_word_reg <= RES_WORD_RESET;
            tmp_word_reg <= RES_WORD_RESET;
            prog_reg <= 1'b0;
            busy_reg <= 1'b0;
            rd_word_reg <= 16'h0000;
            pub_tgl_reg <= 1'b0;
            done_tgl_reg <= 1'b0;
        end
        else
        begin
            mt_q_reg <= mt_s_reg;
            ct_q_reg <= ct_s_reg;
            cst_reg <= cst_next;
            ctim_reg <= ctim_next;
            ntim_reg <= ntim_next;
            win_reg <= win_next;
            hum_cap_reg <= hum_cap_next;
            hum_out_reg <= hum_out_next;
            tmp_out_reg <= tmp_out_next;
            hum_word_reg <= hum_word_next;
            tmp_word_reg <= tmp_word_next;
            prog_reg <= prog_next;
            busy_reg <= busy_next;
            rd_word_reg <= rd_word_next;
            pub_tgl_reg <= pub_tgl_next;
            done_tgl_reg <= done_tgl_next;
        end
    end

    assign core_awake_o = cst_reg != C_SLEEP;
    assign prog_mode_o = prog_reg;
    assign nvm_busy_o = busy_reg;
endmodule
`default_nettype wire

// file: bench/hts_target_checker_properties.sv
// port assertions for the sensor serial target
`timescale 1ns/1ps
`default_nettype none
module hts_target_checker #(
    parameter int CONV14_CYC = 50,
    parameter int POWERUP_WIN_CYC = 20000,
    parameter int NVM_COMMIT_CYC = 100
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic core_awake_o,
    input wire logic prog_mode_o,
    input wire logic nvm_busy_o
);
    localparam int AWAKE_CYC = hts_pkg::WAKE_CYC + 2 * CONV14_CYC + 2;
    localparam int BUSY_MAX = (NVM_COMMIT_CYC > 3000 ? NVM_COMMIT_CYC : 3000) + 4;
    int awake_cnt = 0;
    int busy_cnt = 0;
    int up_cnt = 0;
    always_ff @(posedge clk_i)
    begin
        awake_cnt <= core_awake_o ? awake_cnt + 1 : 0;
        busy_cnt <= nvm_busy_o ? busy_cnt + 1 : 0;
        up_cnt <= rst_i ? 0 : up_cnt + 1;
    end
    reset_quiet_a: assert property (@(posedge clk_i) rst_i |=> !core_awake_o && !prog_mode_o)
        else $error("state not cleared by reset");
    oe_reset_a: assert property (@(posedge link_clk_i) rst_i [*5] |-> !sda_oe_o)
        else $error("data line pulled during reset");
    oe_stable_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        scl_i && $past(scl_i) |-> $stable(sda_oe_o)) else $error("data moved in clock high");
    oe_edge_a: assert property (@(posedge link_clk_i) disable iff (rst_i)
        $changed(sda_oe_o) |-> !scl_i) else $error("data changed outside clock low");
    awake_prog_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(core_awake_o) |-> !prog_mode_o) else $error("measured in programming mode");
    awake_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(core_awake_o) |-> awake_cnt >= AWAKE_CYC - 4 && awake_cnt <= AWAKE_CYC + 4)
        else $error("measurement length wrong");
    busy_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
        nvm_busy_o |-> busy_cnt <= BUSY_MAX) else $error("memory busy too long");
    prog_window_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(prog_mode_o) |-> up_cnt <= POWERUP_WIN_CYC + 3100) else $error("late entry");
endmodule
bind hts_sensor_target hts_target_checker #(.CONV14_CYC(CONV14_CYC),
    .POWERUP_WIN_CYC(POWERUP_WIN_CYC), .NVM_COMMIT_CYC(NVM_COMMIT_CYC))
    u_hts_target_checker (.clk_i, .rst_i, .link_clk_i, .scl_i, .sda_oe_o, .core_awake_o,
    .prog_mode_o, .nvm_busy_o);
`default_nettype wire

// file: bench/hts_bus_master.sv
// behavioural serial bus controller facing the sensor
`timescale 1ns/1ps
`default_nettype none
module hts_bus_master (
    output logic scl_o,
    output logic sda_low_o,
    input wire logic sda_i
);
    int half_ns = 1250;
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // data moves only in clock low, so no false framing
    task automatic bit_x(input logic b, output logic s);
        #200 sda_low_o = !b;
        #(half_ns - 200) scl_o = 1'b1;
        #200 s = sda_i;
        #(half_ns - 200) scl_o = 1'b0;
    endtask
    task automatic start();
        sda_low_o = 1'b1;
        #(half_ns) scl_o = 1'b0;
    endtask
    task automatic stop();
        #200 sda_low_o = 1'b1;
        #(half_ns - 200) scl_o = 1'b1;
        #(half_ns) sda_low_o = 1'b0;
        #(half_ns);
    endtask
    task automatic byte_x(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) bit_x(tx[i], rx[i]);
    endtask
endmodule
`default_nettype wire

// file: bench/hts_sensor_target_test.sv
// self-checking bench for the sensor serial target
`timescale 1ns/1ps
`default_nettype none
module hts_sensor_target_test;
    import hts_pkg::*;
    localparam logic [31:0] ID = 32'h5a3c_0f96; // arbitrary value
    logic clk_i = 1'b0;
    logic link_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [13:0] humid_raw_i = 14'h0;
    logic [13:0] temp_raw_i = 14'h0;
    logic scl_i, sda_low, sda_o, sda_oe_o, core_awake_o, prog_mode_o, nvm_busy_o;
    wire logic sda_i = !(sda_low || sda_oe_o);
    logic ack;
    logic [31:0] r;
    logic [8:0] q;
    int n_errors = 0;
    int samples_checked = 0;
    initial forever #20 clk_i = !clk_i;
    initial
    begin
        #7;
        forever #15 link_clk_i = !link_clk_i;
    end
    hts_sensor_target #(.CONV8_CYC(20), .CONV10_CYC(30), .CONV12_CYC(40), .CONV14_CYC(50),
        .NVM_COMMIT_CYC(100), .SENSOR_ID(ID)) u_hts_sensor_target (
        .clk_i, .rst_i, .link_clk_i, .scl_i, .sda_i, .sda_o, .sda_oe_o, .humid_raw_i,
        .temp_raw_i, .core_awake_o, .prog_mode_o, .nvm_busy_o);
    hts_bus_master u_hts_bus_master (.scl_o(scl_i), .sda_low_o(sda_low), .sda_i);
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic xfer(input logic [7:0] a, input int n, input logic [23:0] d);
        r = '0;
        u_hts_bus_master.start();
        u_hts_bus_master.byte_x({a, 1'b1}, q);
        ack = q[0];
        for (int i = 0; i < n; i++)
        begin
            u_hts_bus_master.byte_x(a[0] ? {8'hff, 1'(i == n - 1)} : {d[23 - 8 * i -: 8], 1'b1}, q);
            r = {r[23:0], q[8:1]};
        end
        u_hts_bus_master.stop();
    endtask
    task automatic t_prog();
        logic [7:0] regs [4] = '{8'h06, 8'h11, 8'h1e, 8'h1f};
        logic [15:0] vals [4] = '{16'h0c00, 16'h0c00, ID[31:16], ID[15:0]};
        xfer(8'h88, 3, 24'ha00000);
        repeat (NVM_LOAD_CYC + 20) @(posedge clk_i);
        chk("prog mode", 1, prog_mode_o);
        xfer(8'h88, 0, '0);
        repeat (20) @(posedge clk_i);
        chk("awake in prog", 0, core_awake_o);
        foreach (regs[i])
        begin
            xfer(8'h88, 3, {regs[i], 16'h0});
            repeat (NVM_LOAD_CYC + 20) @(posedge clk_i);
            xfer(8'h89, 3, '0);
            chk("nvm word", {8'h01, vals[i]}, r);
        end
        xfer(8'h88, 3, 24'h460800);
        chk("commit busy", 1, nvm_busy_o);
        repeat (120) @(posedge clk_i);
        xfer(8'h88, 3, 24'h060000);
        repeat (NVM_LOAD_CYC + 20) @(posedge clk_i);
        xfer(8'h89, 3, '0);
        chk("res write", 24'h010800, r);
        xfer(8'h88, 3, 24'h460c00);
        repeat (120) @(posedge clk_i);
        xfer(8'h88, 3, 24'h800000);
        repeat (NVM_LOAD_CYC + 20) @(posedge clk_i);
        chk("prog exit", 0, prog_mode_o);
        $display("t_prog done");
    endtask
    task automatic t_meas();
        @(posedge clk_i);
        humid_raw_i <= 14'h2a5b;
        temp_raw_i <= 14'h1c3d;
        xfer(8'h8a, 0, '0);
        chk("foreign ack", 1, ack);
        xfer(8'h89, 1, '0);
        chk("early status", 1, r[7:6]);
        xfer(8'h88, 0, '0);
        chk("request ack", 0, ack);
        chk("open drain", 0, sda_o);
        repeat (200) @(posedge clk_i);
        chk("awake", 1, core_awake_o);
        repeat (2700) @(posedge clk_i);
        chk("asleep", 0, core_awake_o);
        xfer(8'h89, 4, '0);
        chk("fetch ack", 0, ack);
        chk("fetch", {2'b00, 14'h2a5b, 14'h1c3d, 2'b00}, r & 32'hffff_fffc);
        u_hts_bus_master.half_ns = 5000;
        xfer(8'h89, 2, '0);
        chk("stale fetch", {2'b01, 14'h2a5b}, r);
        $display("t_meas done");
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        t_prog();
        t_meas();
        wrap_up();
    end
    initial
    begin
        #4ms;
        n_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
